// *** design/gir_defines.svh ***
// Register map, field positions, reset values and timing for the interrupt block
`ifndef GIR_DEFINES_SVH
`define GIR_DEFINES_SVH
// Register byte addresses
`define GIR_ADDR_FRAME_SYNC_PIN_FLAGS 8'h36
`define GIR_ADDR_PIN_CFG 8'h37
`define GIR_ADDR_MASK 8'h38
`define GIR_ADDR_FLAGS 8'h3A
`define GIR_ADDR_TEMP_H 8'h41
`define GIR_ADDR_TEMP_L 8'h42
`define GIR_ADDR_RATE_XH 8'h43
`define GIR_ADDR_RATE_XL 8'h44
`define GIR_ADDR_RATE_YH 8'h45
`define GIR_ADDR_RATE_YL 8'h46
`define GIR_ADDR_RATE_ZH 8'h47
`define GIR_ADDR_RATE_ZL 8'h48
`define GIR_ADDR_TEMP_RST 8'h68
// Pin configuration fields
`define GIR_CFG_ACT_LOW 7
`define GIR_CFG_OPEN_DRAIN 6
`define GIR_CFG_HOLD 5
`define GIR_CFG_ANY_RD_CLR 4
`define GIR_CFG_FS_ACT_LOW 3
`define GIR_CFG_FS_IRQ_EN 2
`define GIR_CFG_SECOND_PIN 0
`define GIR_CFG_USED 8'hFD
// Mask and flag fields
`define GIR_BIT_OVERFLOW 4
`define GIR_BIT_DRIVE_RDY 2
`define GIR_BIT_DATA_RDY 0
`define GIR_FLAG_USED 8'h15
`define GIR_BIT_FRAME_SYNC_PIN 7
`define GIR_BIT_TEMP_RST 0
// Reset values
`define GIR_RST_CFG 8'h00
`define GIR_RST_MASK 8'h00
`define GIR_RST_FLAGS 8'h00
// Timing: pulse width in microseconds, clock in MHz
`define GIR_PULSE_US 50
`define GIR_CLK_MHZ 125
`endif

// *** design/gir_pkg.sv ***
// Types shared by the interrupt and sample register block
package gir_pkg;
    // One captured sensor sample set, high byte in bits 15:8
    typedef struct packed {
        logic [15:0] temp;
        logic [15:0] rate_x_sample;
        logic [15:0] rate_y_sample;
        logic [15:0] rate_z_sample;
    } gir_sample_t;

    // Hardware events raised by the sensor core, one-cycle pulses
    typedef struct packed {
        logic overflow;
        logic drive_ready;
        logic data_ready;
    } gir_events_t;
endpackage : gir_pkg

// *** design/gir_regs.sv ***
// Interrupt configuration, flags, pin drive and sample registers
`include "gir_defines.svh"

module gir_regs #(
    parameter int PULSE_CYC = `GIR_PULSE_US * `GIR_CLK_MHZ
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register access from the serial port engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Sensor core side
    input wire gir_pkg::gir_sample_t sample_in,
    input wire logic sample_valid,
    input wire gir_pkg::gir_events_t events,
    input wire logic full_conditioning_reset,
    output logic temp_path_rst,
    // Frame-sync pin
    input wire logic frame_sync_pin,
    // Interrupt pins
    output logic irq_main_out,
    output logic irq_main_oe,
    output logic irq_aux_out,
    output logic irq_aux_oe
);
    localparam int CW = $clog2(PULSE_CYC + 1);

    // Refuse a pulse width the counter cannot hold
    if (PULSE_CYC < 1) begin : g_bad_pulse
        $error("PULSE_CYC must be at least 1");
    end

    logic [7:0] cfg_r;
    logic [7:0] mask_r;
    logic [7:0] flags_r;
    logic fs_flag_r;
    gir_pkg::gir_sample_t samp_r;
    logic fs_s1_r;
    logic fs_s2_r;
    logic fs_s3_r;
    logic fs_edge;
    logic rd_flags;
    logic rd_frame_sync_pin;
    logic [2:0] ev_en;
    logic [1:0] trig;
    logic [1:0] pend;
    logic [1:0] act;
    logic [CW-1:0] cnt_r [2];
    logic [1:0] pin_out_r;
    logic [1:0] pin_oe_r;

    // Byte select of a 16-bit sample, high byte on the even offset
    function automatic logic [7:0] pick(input logic [15:0] w, input logic hi);
        pick = hi ? w[15:8] : w[7:0];
    endfunction : pick

    // Pin drive: level follows polarity, open drain drives active level only
    function automatic logic [1:0] drive(input logic a, input logic [7:0] c);
        logic lvl;
        lvl = a ^ c[`GIR_CFG_ACT_LOW];
        drive = {lvl, a | ~c[`GIR_CFG_OPEN_DRAIN]};
    endfunction : drive

    // Configuration and mask writes
    // Reserved bits are dropped on the way in so they always read back as zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= `GIR_RST_CFG;
            mask_r <= `GIR_RST_MASK;
        end else if (reg_wr) begin
            if (reg_addr == `GIR_ADDR_PIN_CFG) begin
                cfg_r <= reg_wdata & `GIR_CFG_USED;
            end
            if (reg_addr == `GIR_ADDR_MASK) begin
                mask_r <= reg_wdata & `GIR_FLAG_USED;
            end
        end
    end

    // Temperature path reset is a self-clearing pulse; samples are untouched
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            temp_path_rst <= 1'b0;
        end else begin
            temp_path_rst <= reg_wr && reg_addr == `GIR_ADDR_TEMP_RST
                && reg_wdata[`GIR_BIT_TEMP_RST];
        end
    end

    // Sample capture; only the full conditioning reset clears it
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            samp_r <= '0;
        end else if (full_conditioning_reset) begin
            samp_r <= '0;
        end else if (sample_valid) begin
            samp_r <= sample_in;
        end
    end

    // Frame-sync pin synchroniser plus one stage for edge detection
    // Only the second and third stages feed logic; the first may still be settling
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fs_s1_r <= 1'b0;
            fs_s2_r <= 1'b0;
            fs_s3_r <= 1'b0;
        end else begin
            fs_s1_r <= frame_sync_pin;
            fs_s2_r <= fs_s1_r;
            fs_s3_r <= fs_s2_r;
        end
    end

    // Transition into the configured active level
    always_comb begin
        fs_edge = (fs_s2_r ^ cfg_r[`GIR_CFG_FS_ACT_LOW])
            & ~(fs_s3_r ^ cfg_r[`GIR_CFG_FS_ACT_LOW]);
    end

    // Read strobes that clear flags, optionally any read at all
    // The any-read mode trades precise clearing for fewer host accesses
    always_comb begin
        rd_flags = reg_rd && (reg_addr == `GIR_ADDR_FLAGS
            || cfg_r[`GIR_CFG_ANY_RD_CLR]);
        rd_frame_sync_pin = reg_rd && (reg_addr == `GIR_ADDR_FRAME_SYNC_PIN_FLAGS
            || cfg_r[`GIR_CFG_ANY_RD_CLR]);
    end

    // Sticky flags; a set in the same cycle as a read-clear wins
    // Non-blocking order puts the sets last, so an event never gets lost
    // when the host reads the flags in the very cycle it arrives
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= `GIR_RST_FLAGS;
        end else begin
            if (rd_flags) begin
                flags_r <= '0;
            end
            if (events.overflow) begin
                flags_r[`GIR_BIT_OVERFLOW] <= 1'b1;
            end
            if (events.drive_ready) begin
                flags_r[`GIR_BIT_DRIVE_RDY] <= 1'b1;
            end
            if (events.data_ready) begin
                flags_r[`GIR_BIT_DATA_RDY] <= 1'b1;
            end
        end
    end

    // Frame-sync flag, raised only while its interrupt is enabled
    // Polled through its own byte so the main flag byte keeps its layout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fs_flag_r <= 1'b0;
        end else if (fs_edge && cfg_r[`GIR_CFG_FS_IRQ_EN]) begin
            fs_flag_r <= 1'b1;
        end else if (rd_frame_sync_pin) begin
            fs_flag_r <= 1'b0;
        end
    end

    // Enabled new events and enabled pending flags, routed per pin
    // Masked flags still latch but never reach a pin
    always_comb begin
        ev_en[2] = events.overflow & mask_r[`GIR_BIT_OVERFLOW];
        ev_en[1] = events.drive_ready & mask_r[`GIR_BIT_DRIVE_RDY];
        ev_en[0] = events.data_ready & mask_r[`GIR_BIT_DATA_RDY];
        // Data ready always on main pin, others follow the second-pin bit
        trig[0] = ev_en[0] | (~cfg_r[`GIR_CFG_SECOND_PIN]
            & (ev_en[2] | ev_en[1] | (fs_edge & cfg_r[`GIR_CFG_FS_IRQ_EN])));
        trig[1] = cfg_r[`GIR_CFG_SECOND_PIN]
            & (ev_en[2] | ev_en[1] | (fs_edge & cfg_r[`GIR_CFG_FS_IRQ_EN]));
        pend[0] = (flags_r[0] & mask_r[0]) | (~cfg_r[`GIR_CFG_SECOND_PIN]
            & (|(flags_r[4:1] & mask_r[4:1]) | fs_flag_r));
        pend[1] = cfg_r[`GIR_CFG_SECOND_PIN]
            & (|(flags_r[4:1] & mask_r[4:1]) | fs_flag_r);
    end

    // Per pin: pulse counter, active term and registered pad drive
    for (genvar p = 0; p < 2; p++) begin : g_pin
        // Pulse mode restarts the full width on every new interrupt
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                cnt_r[p] <= '0;
            end else if (trig[p] && !cfg_r[`GIR_CFG_HOLD]) begin
                cnt_r[p] <= CW'(PULSE_CYC);
            end else if (cnt_r[p] != '0) begin
                cnt_r[p] <= cnt_r[p] - CW'(1);
            end
        end

        // Hold mode follows the flags, pulse mode the counter
        always_comb begin
            act[p] = cfg_r[`GIR_CFG_HOLD] ? pend[p] : (cnt_r[p] != '0);
        end

        // Pad flops keep the pin free of decode glitches
        // at the cost of one cycle of extra latency on every interrupt
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                pin_out_r[p] <= 1'b0;
                pin_oe_r[p] <= 1'b1;
            end else begin
                {pin_out_r[p], pin_oe_r[p]} <= drive(act[p], cfg_r);
            end
        end
    end

    assign irq_main_out = pin_out_r[0];
    assign irq_main_oe = pin_oe_r[0];
    assign irq_aux_out = pin_out_r[1];
    assign irq_aux_oe = pin_oe_r[1];

    // Registered read data, one cycle after the read strobe
    // Samples are not shadowed, so a host must fetch both bytes back to back
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `GIR_ADDR_FRAME_SYNC_PIN_FLAGS: reg_rdata <= {fs_flag_r, 7'h00};
                `GIR_ADDR_PIN_CFG: reg_rdata <= cfg_r;
                `GIR_ADDR_MASK: reg_rdata <= mask_r;
                `GIR_ADDR_FLAGS: reg_rdata <= flags_r;
                `GIR_ADDR_TEMP_H: reg_rdata <= pick(samp_r.temp, 1'b1);
                `GIR_ADDR_TEMP_L: reg_rdata <= pick(samp_r.temp, 1'b0);
                `GIR_ADDR_RATE_XH: reg_rdata <= pick(samp_r.rate_x_sample, 1'b1);
                `GIR_ADDR_RATE_XL: reg_rdata <= pick(samp_r.rate_x_sample, 1'b0);
                `GIR_ADDR_RATE_YH: reg_rdata <= pick(samp_r.rate_y_sample, 1'b1);
                `GIR_ADDR_RATE_YL: reg_rdata <= pick(samp_r.rate_y_sample, 1'b0);
                `GIR_ADDR_RATE_ZH: reg_rdata <= pick(samp_r.rate_z_sample, 1'b1);
                `GIR_ADDR_RATE_ZL: reg_rdata <= pick(samp_r.rate_z_sample, 1'b0);
                default: reg_rdata <= 8'h00; // Unmapped and write-only read zero
            endcase
        end
    end

    // Checks on flag, pin and sample behaviour
    // Pin checks compare against the settings seen one edge earlier
    chk_data_ready_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        events.data_ready |=> flags_r[`GIR_BIT_DATA_RDY])
        else $error("data ready flag not set");

    chk_overflow_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        events.overflow |=> flags_r[`GIR_BIT_OVERFLOW])
        else $error("overflow flag not set");

    chk_flag_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == `GIR_ADDR_FLAGS && !events.data_ready
        |=> !flags_r[`GIR_BIT_DATA_RDY])
        else $error("data ready flag not cleared by read");

    chk_pulse_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
        trig[0] && !cfg_r[`GIR_CFG_HOLD] |=> cnt_r[0] == CW'(PULSE_CYC)
        ##1 act[0] [*2])
        else $error("pulse did not start at full width");

    chk_pin_polarity: assert property (@(posedge clk_sys) disable iff (!rst_n)
        1'b1 |=> irq_main_out == ($past(act[0]) ^ $past(cfg_r[`GIR_CFG_ACT_LOW])))
        else $error("main pin level wrong for polarity");

    chk_open_drain: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !act[1] && cfg_r[`GIR_CFG_OPEN_DRAIN] |=> !irq_aux_oe)
        else $error("open drain pin driven while idle");

    chk_aux_unused: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfg_r[`GIR_CFG_SECOND_PIN] && cfg_r[`GIR_CFG_HOLD]
        |=> irq_aux_out == $past(cfg_r[`GIR_CFG_ACT_LOW]))
        else $error("aux pin active with second pin off");

    chk_temp_rst_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
        temp_path_rst && !sample_valid && !full_conditioning_reset |=> $stable(samp_r))
        else $error("temperature reset disturbed samples");

    chk_full_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        full_conditioning_reset |=> samp_r == '0)
        else $error("samples not cleared by full reset");

    chk_frame_sync_pin_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fs_edge && cfg_r[`GIR_CFG_FS_IRQ_EN] |=> fs_flag_r)
        else $error("frame-sync flag not raised");

    chk_frame_sync_pin_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfg_r[`GIR_CFG_FS_IRQ_EN] && !fs_flag_r |=> !fs_flag_r)
        else $error("frame-sync flag raised while disabled");

    chk_frame_sync_pin_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        rd_frame_sync_pin && !(fs_edge && cfg_r[`GIR_CFG_FS_IRQ_EN]) |=> !fs_flag_r)
        else $error("frame-sync flag not cleared by read");

    chk_drive_ready_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        events.drive_ready |=> flags_r[`GIR_BIT_DRIVE_RDY])
        else $error("drive ready flag not set");

    chk_any_read_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && cfg_r[`GIR_CFG_ANY_RD_CLR] && events == '0 |=> flags_r == 8'h00)
        else $error("flags not cleared by any read");

    chk_flags_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_rd && reg_addr == `GIR_ADDR_FLAGS |=> reg_rdata == $past(flags_r))
        else $error("flag byte read back wrong");

    chk_rdata_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    chk_temp_rst_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        reg_wr && reg_addr == `GIR_ADDR_TEMP_RST && reg_wdata[`GIR_BIT_TEMP_RST]
        |=> temp_path_rst)
        else $error("temperature reset pulse missing");

    chk_push_pull: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !cfg_r[`GIR_CFG_OPEN_DRAIN] |=> irq_main_oe && irq_aux_oe)
        else $error("push-pull pin released");

    chk_masked_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_r[`GIR_CFG_HOLD] && !(|(flags_r & mask_r)) && !fs_flag_r
        |=> irq_main_out == $past(cfg_r[`GIR_CFG_ACT_LOW])
        && irq_aux_out == $past(cfg_r[`GIR_CFG_ACT_LOW]))
        else $error("pin active with no enabled flag");

    chk_data_ready_main: assert property (@(posedge clk_sys) disable iff (!rst_n)
        cfg_r[`GIR_CFG_HOLD] && flags_r[`GIR_BIT_DATA_RDY] && mask_r[`GIR_BIT_DATA_RDY]
        |=> irq_main_out == !$past(cfg_r[`GIR_CFG_ACT_LOW]))
        else $error("data ready not on main pin");

    // Cycles the main pin term has stood in pulse mode; a retrigger restarts it
    logic [CW:0] width_r;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            width_r <= '0;
        end else if (trig[0] || !act[0] || cfg_r[`GIR_CFG_HOLD]) begin
            width_r <= '0;
        end else begin
            width_r <= width_r + (CW+1)'(1);
        end
    end

    chk_width_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        width_r <= (CW+1)'(PULSE_CYC))
        else $error("pulse longer than its fixed width");

    // Scenarios that the bench should reach at least once

    cov_pulse_done: cover property (@(posedge clk_sys) disable iff (!rst_n)
        act[0] ##1 !act[0]);
    cov_frame_sync_pin_aux: cover property (@(posedge clk_sys) disable iff (!rst_n)
        fs_flag_r && cfg_r[`GIR_CFG_SECOND_PIN] && act[1]);
    cov_set_and_clear: cover property (@(posedge clk_sys) disable iff (!rst_n)
        rd_flags && events.data_ready);
    cov_retrigger: cover property (@(posedge clk_sys) disable iff (!rst_n)
        trig[0] && act[0]);
    cov_drain_release: cover property (@(posedge clk_sys) disable iff (!rst_n)
        irq_main_oe ##1 !irq_main_oe);
endmodule : gir_regs

// *** tb/gir_host_model.sv ***
// Host processor model: register port master and interrupt pin wires
module gir_host_model (
    // Clock
    input wire logic clk_sys,
    // Register port toward the device
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    // Interrupt pins and the board pull level
    input wire logic irq_main_out,
    input wire logic irq_main_oe,
    input wire logic irq_aux_out,
    input wire logic irq_aux_oe,
    input wire logic pull_hi,
    output logic main_lvl,
    output logic aux_lvl
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin falls to the board pull, never to the last driven value
    assign main_lvl = irq_main_oe ? irq_main_out : pull_hi;
    assign aux_lvl = irq_aux_oe ? irq_aux_out : pull_hi;

    // Port idle at time zero
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // One write strobe, launched just after an edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_wr = 1'b0;
    endtask : wr

    // One byte read; data is registered so it shows after the sampling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd

    // Both bytes of a sample back to back, so no new capture can split them
    task automatic rd16(input logic [7:0] a, output logic [15:0] w);
        @(posedge clk_sys);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        reg_addr = a + 8'h01;
        w[15:8] = reg_rdata;
        @(posedge clk_sys);
        #1;
        reg_rd = 1'b0;
        w[7:0] = reg_rdata;
    endtask : rd16
endmodule : gir_host_model

// *** tb/gir_regs_tb_top.sv ***
// Self-checking bench for the interrupt and sample register block
`include "gir_defines.svh"

module gir_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PULSE = 8;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, v, c;
    logic reg_wr, reg_rd, temp_path_rst, main_lvl, aux_lvl;
    logic sample_valid = 1'b0, full_conditioning_reset = 1'b0;
    logic frame_sync_pin = 1'b0, pull_hi = 1'b0;
    logic irq_main_out, irq_main_oe, irq_aux_out, irq_aux_oe;
    gir_pkg::gir_sample_t sample_in = '0;
    gir_pkg::gir_events_t events = '0;
    logic [63:0] s;
    int errors = 0;
    int compares = 0;
    int n;

    always #4 clk_sys = ~clk_sys;

    gir_regs #(.PULSE_CYC(PULSE)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_in(sample_in), .sample_valid(sample_valid),
        .events(events), .full_conditioning_reset(full_conditioning_reset),
        .temp_path_rst(temp_path_rst), .frame_sync_pin(frame_sync_pin),
        .irq_main_out(irq_main_out), .irq_main_oe(irq_main_oe),
        .irq_aux_out(irq_aux_out), .irq_aux_oe(irq_aux_oe));
    gir_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq_main_out(irq_main_out), .irq_main_oe(irq_main_oe), .irq_aux_out(irq_aux_out),
        .irq_aux_oe(irq_aux_oe), .pull_hi(pull_hi), .main_lvl(main_lvl), .aux_lvl(aux_lvl));

    task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk8

    task automatic chk1(input string nm, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", nm, e, g);
        end
    endtask : chk1

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk8($sformatf("reg %h", a), e, v);
    endtask : rdchk

    // Pull follows the inactive level, so a released pin reads inactive
    task automatic cfg_set(input logic [7:0] cv);
        host.wr(`GIR_ADDR_PIN_CFG, cv);
        pull_hi = cv[7];
    endtask : cfg_set

    task automatic ev(input logic [2:0] e);
        @(posedge clk_sys);
        #1;
        events = e;
        @(posedge clk_sys);
        #1;
        events = '0;
    endtask : ev

    // Settle three edges, then compare both pins' level and enable
    task automatic pins(input logic [7:0] cv, input logic m, input logic a);
        repeat (3) @(posedge clk_sys);
        #1;
        chk1("main level", m ^ cv[7], main_lvl);
        chk1("main enable", cv[6] ? m : 1'b1, irq_main_oe);
        chk1("aux level", a ^ cv[7], aux_lvl);
        chk1("aux enable", cv[6] ? a : 1'b1, irq_aux_oe);
    endtask : pins

    // Samples read back as 16-bit words, high byte at the lower address
    task automatic words(input logic [63:0] e);
        logic [15:0] w;
        for (int k = 0; k < 4; k++) begin
            host.rd16(`GIR_ADDR_TEMP_H + 8'(2 * k), w);
            chk8("sample high", e[63 - 16 * k -: 8], w[15:8]);
            chk8("sample low", e[55 - 16 * k -: 8], w[7:0]);
        end
    endtask : words

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #60us;
        errors++;
        conclude();
    end

    initial begin
        void'($urandom(32'h0d46bdf1));
        repeat (6) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        rdchk(`GIR_ADDR_PIN_CFG, `GIR_RST_CFG);
        rdchk(`GIR_ADDR_MASK, `GIR_RST_MASK);
        rdchk(`GIR_ADDR_FLAGS, `GIR_RST_FLAGS);
        rdchk(`GIR_ADDR_TEMP_RST, 8'h00);
        rdchk(8'h50, 8'h00);
        // Random settings read back with reserved bits at zero
        repeat (8) begin
            c = 8'($urandom);
            s[7:0] = 8'($urandom);
            cfg_set(c);
            host.wr(`GIR_ADDR_MASK, s[7:0]);
            rdchk(`GIR_ADDR_PIN_CFG, c & `GIR_CFG_USED);
            rdchk(`GIR_ADDR_MASK, s[7:0] & `GIR_FLAG_USED);
        end
        $display("Test registers done");
        s = {$urandom, $urandom};
        @(posedge clk_sys);
        #1;
        sample_in = s;
        sample_valid = 1'b1;
        @(posedge clk_sys);
        #1;
        sample_valid = 1'b0;
        host.wr(`GIR_ADDR_TEMP_H, 8'hFF);
        words(s);
        host.wr(`GIR_ADDR_TEMP_RST, 8'h01);
        chk1("temp reset pulse", 1'b1, temp_path_rst);
        @(posedge clk_sys);
        #1;
        chk1("temp reset end", 1'b0, temp_path_rst);
        host.wr(`GIR_ADDR_TEMP_RST, 8'h00);
        chk1("temp reset idle", 1'b0, temp_path_rst);
        words(s);
        full_conditioning_reset = 1'b1;
        @(posedge clk_sys);
        #1;
        full_conditioning_reset = 1'b0;
        words('0);
        $display("Test samples done");
        // Masked events set flags but leave the pins alone
        cfg_set(8'h20);
        host.wr(`GIR_ADDR_MASK, 8'h00);
        rdchk(`GIR_ADDR_FLAGS, 8'h00);
        ev(3'b111);
        pins(8'h20, 1'b0, 1'b0);
        rdchk(`GIR_ADDR_FLAGS, 8'h15);
        rdchk(`GIR_ADDR_FLAGS, 8'h00);
        // Every polarity, drive style and routing in hold mode
        for (int i = 0; i < 8; i++) begin
            c = {i[1], i[0], 1'b1, 4'b0000, i[2]};
            cfg_set(c);
            host.wr(`GIR_ADDR_MASK, 8'h15);
            pins(c, 1'b0, 1'b0);
            ev(3'b001);
            pins(c, 1'b1, 1'b0);
            rdchk(`GIR_ADDR_FLAGS, 8'h01);
            pins(c, 1'b0, 1'b0);
            ev(3'b110);
            pins(c, ~i[2], i[2]);
            rdchk(`GIR_ADDR_FLAGS, 8'h14);
        end
        $display("Test pins done");
        // Any-read-clear on, then off
        cfg_set(8'h30);
        ev(3'b001);
        rdchk(`GIR_ADDR_PIN_CFG, 8'h30);
        rdchk(`GIR_ADDR_FLAGS, 8'h00);
        cfg_set(8'h20);
        ev(3'b001);
        rdchk(`GIR_ADDR_MASK, 8'h15);
        rdchk(`GIR_ADDR_FLAGS, 8'h01);
        $display("Test read clear done");
        // Frame-sync edges at both active levels, enabled and disabled
        for (int i = 0; i < 4; i++) begin
            c = {4'h2, i[0], i[1], 2'b00};
            frame_sync_pin = i[0];
            cfg_set(c);
            repeat (6) @(posedge clk_sys);
            host.rd(`GIR_ADDR_FRAME_SYNC_PIN_FLAGS, v);
            frame_sync_pin = ~i[0];
            repeat (6) @(posedge clk_sys);
            rdchk(`GIR_ADDR_FRAME_SYNC_PIN_FLAGS, i[1] ? 8'h80 : 8'h00);
            rdchk(`GIR_ADDR_FRAME_SYNC_PIN_FLAGS, 8'h00);
        end
        $display("Test frame sync done");
        // Pulse mode: fixed width, flag stays set
        cfg_set(8'h00);
        rdchk(`GIR_ADDR_FLAGS, 8'h00);
        ev(3'b001);
        n = 0;
        repeat (20) begin
            @(posedge clk_sys);
            #1;
            if (main_lvl === 1'b1) begin
                n++;
            end
        end
        chk8("pulse width", 8'(PULSE), 8'(n));
        rdchk(`GIR_ADDR_FLAGS, 8'h01);
        $display("Test pulse done");
        conclude();
    end
endmodule : gir_regs_tb_top
